// [fpc_capture.sv]
// What this block does
// - Capture mode follows bit 1 of the miscellaneous configuration command: 1 turns it on, 0 off.
// - The 32-byte captured set is read back one byte per read request at rd_index, also during normal operation.
// - While capture mode is on, the RAM buffer is refreshed once per firmware cycle, except while a save or reload runs.
// - Control value 1 copies the saved set from nonvolatile memory into the RAM buffer.
// - Control value 2 saves the RAM buffer to nonvolatile memory, only while output is disabled.
// - A fault whose response is shutdown saves the buffer automatically; a retry fault does not.
// - A save may take up to 1400 us and the host must let it finish.
// - The readout command answers with the current RAM buffer.
// - Saved data survives a power cycle and is reachable by reload then read with capture off.
// - After power-up the default store (default_config) is applied as the configuration.
// - The restore-default command reloads settings from the default store.
// - Restore-default is a send-byte with command code 12h and no data.
`timescale 1ns/100ps
`include "fpc_regs.svh"

module fpc_capture #(
	parameter int BYTES       = `FPC_BUF_BYTES,
	parameter int SAVE_CYCLES = `FPC_SAVE_CYCLES,
	parameter int CFG_BYTES   = 8
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      cmd_valid,
	input  wire logic [7:0]                cmd_code,
	input  wire logic                      cmd_has_data,
	input  wire logic [7:0]                cmd_data,
	input  wire logic                      rd_req,
	input  wire logic [$clog2(BYTES)-1:0]  rd_index,
	output logic      [7:0]                rd_data,
	output logic                           rd_valid,
	input  wire logic                      fw_tick,
	input  wire logic [BYTES*8-1:0]        live_params,
	input  wire logic                      output_enabled,
	input  wire logic                      fault_event,
	input  wire logic                      fault_shutdown,
	output logic                           capture_on,
	output logic                           busy,
	output logic      [CFG_BYTES*8-1:0]    config_out,
	output logic                           config_valid,
	input  wire logic [CFG_BYTES*8-1:0]    default_config
);
	import fpc_pkg::*;

	localparam int AW = $clog2(BYTES);
	localparam int TW = $clog2(SAVE_CYCLES + 1);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire is_misc    = cmd_valid && cmd_has_data && cmd_code == `FPC_CMD_MISC_CONFIG;
	wire is_ctrl    = cmd_valid && cmd_has_data && cmd_code == `FPC_CMD_STORE_CONTROL;
	wire is_restore = cmd_valid && !cmd_has_data && cmd_code == `FPC_CMD_RESTORE_DEFAULT;
	wire req_reload = is_ctrl && cmd_data == `FPC_CTRL_RELOAD;
	wire req_save   = is_ctrl && cmd_data == `FPC_CTRL_SAVE && !output_enabled;
	wire auto_save  = fault_event && fault_shutdown;

	fpc_state_t          state_q, state_d;
	logic [7:0]          buf_q [BYTES];
	logic                capture_q;
	logic [AW:0]         idx_q;
	logic [TW-1:0]       wait_q;
	logic                pend_save_q;
	logic [7:0]          cfg_q [CFG_BYTES];
	logic                cfg_valid_q;
	logic                rd_valid_q;
	logic [7:0]          rd_data_q;
	logic [7:0]          nv_rd_data;

	wire walk_done = idx_q == (AW+1)'(BYTES);
	wire wait_done = wait_q == TW'(SAVE_CYCLES - 1);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			FPC_IDLE: begin
				if (auto_save || req_save || pend_save_q) begin
					state_d = FPC_SAVE;
				end else if (req_reload) begin
					state_d = FPC_RELOAD;
				end else if (is_restore) begin
					state_d = FPC_DEFAULT;
				end
			end
			FPC_SAVE: begin
				if (walk_done && wait_done) begin
					state_d = FPC_IDLE;
				end
			end
			FPC_RELOAD: begin
				if (walk_done) begin
					state_d = FPC_IDLE;
				end
			end
			FPC_INIT: begin
				state_d = FPC_IDLE;
			end
			FPC_DEFAULT: begin
				state_d = FPC_IDLE;
			end
			default: begin
				state_d = FPC_IDLE;
			end
		endcase
	end

	wire in_save   = state_q == FPC_SAVE;
	wire in_reload = state_q == FPC_RELOAD;
	wire nv_wr     = in_save && !walk_done;
	wire [AW-1:0] nv_addr = idx_q[AW-1:0];
	wire [AW-1:0] rl_addr = AW'(idx_q - (AW+1)'(1));

	fpc_nv_store #(
		.DEPTH(BYTES)
	) u_nv (
		.clk     (clk),
		.wr_en   (nv_wr),
		.wr_addr (nv_addr),
		.wr_data (buf_q[nv_addr]),
		.rd_addr (nv_addr),
		.rd_data (nv_rd_data)
	);

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= FPC_INIT;
			capture_q   <= 1'b0;
			idx_q       <= '0;
			wait_q      <= '0;
			pend_save_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (is_misc) begin
				capture_q <= cmd_data[`FPC_MISC_CAPTURE_BIT];
			end
			if (state_q != FPC_IDLE && auto_save) begin
				pend_save_q <= 1'b1;
			end else if (state_q == FPC_IDLE) begin
				pend_save_q <= 1'b0;
			end
			if (state_q != state_d) begin
				idx_q <= '0;
			end else if ((in_save || in_reload) && !walk_done) begin
				idx_q <= idx_q + (AW+1)'(1);
			end
			if (!in_save || state_d != FPC_SAVE) begin
				wait_q <= '0;
			end else if (!wait_done) begin
				wait_q <= wait_q + TW'(1);
			end
		end
	end

	// ----------------------------------------
	// Capture buffer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		for (int i = 0; i < BYTES; i++) begin
			if (in_reload && idx_q != '0 && rl_addr == AW'(i)) begin
				buf_q[i] <= nv_rd_data;
			end else if (capture_q && fw_tick && !in_save && !in_reload) begin
				buf_q[i] <= live_params[i*8 +: 8];
			end
		end
	end

	// ----------------------------------------
	// Configuration store
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_valid_q <= 1'b0;
		end else if (state_q == FPC_INIT || state_q == FPC_DEFAULT) begin
			cfg_valid_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (state_q == FPC_INIT || state_q == FPC_DEFAULT) begin
			for (int i = 0; i < CFG_BYTES; i++) begin
				cfg_q[i] <= default_config[i*8 +: 8];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < CFG_BYTES; i++) begin
			config_out[i*8 +: 8] = cfg_valid_q ? cfg_q[i] : 8'h00;
		end
	end

	// ----------------------------------------
	// Block readout
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 8'h00;
		end else begin
			rd_valid_q <= rd_req;
			if (rd_req) begin
				rd_data_q <= buf_q[rd_index];
			end
		end
	end

	assign rd_data      = rd_data_q;
	assign rd_valid     = rd_valid_q;
	assign capture_on   = capture_q;
	assign busy         = state_q != FPC_IDLE;
	assign config_valid = cfg_valid_q;
endmodule : fpc_capture

// [fpc_regs.svh]
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FPC_CMD_RESTORE_DEFAULT 8'h12
`define FPC_CMD_MISC_CONFIG     8'he9
`define FPC_CMD_READOUT         8'hd7
`define FPC_CMD_STORE_CONTROL   8'hf3

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define FPC_MISC_CAPTURE_BIT    1
`define FPC_CTRL_RELOAD         8'h01
`define FPC_CTRL_SAVE           8'h02
`define FPC_BUF_BYTES           32

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPC_CLK_NS              50
`define FPC_SAVE_MAX_US         1400
`define FPC_SAVE_CYCLES         ((`FPC_SAVE_MAX_US * 1000) / `FPC_CLK_NS)

`endif

// [fpc_pkg.sv]
package fpc_pkg;

	typedef enum logic [2:0] {
		FPC_IDLE    = 3'b000,
		FPC_SAVE    = 3'b001,
		FPC_RELOAD  = 3'b010,
		FPC_INIT    = 3'b011,
		FPC_DEFAULT = 3'b100
	} fpc_state_t;

endpackage : fpc_pkg

// [fpc_nv_store.sv]
`timescale 1ns/100ps
`include "fpc_regs.svh"

// ----------------------------------------
// Nonvolatile array: capture area only
// ----------------------------------------
module fpc_nv_store #(
	parameter int DEPTH = 32
) (
	input  wire logic                     clk,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [7:0]               wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [7:0]               rd_data
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : fpc_nv_store

// [fpc_capture_chk.sv]
`timescale 1ns/100ps
`include "fpc_regs.svh"
module fpc_capture_chk #(
	parameter int SAVE_CYCLES = 40
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        cmd_has_data,
	input wire logic [7:0]  cmd_data,
	input wire logic        rd_req,
	input wire logic        rd_valid,
	input wire logic        output_enabled,
	input wire logic        fault_event,
	input wire logic        fault_shutdown,
	input wire logic        capture_on,
	input wire logic        busy,
	input wire logic [63:0] config_out,
	input wire logic [63:0] default_config
);
	int busy_len_q;
	wire go   = cmd_valid && !busy && !fault_event;
	wire save = go && cmd_has_data && cmd_code == `FPC_CMD_STORE_CONTROL && cmd_data == `FPC_CTRL_SAVE;
	wire cap  = cmd_valid && cmd_code == `FPC_CMD_MISC_CONFIG && cmd_has_data;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len_q <= 0;
		end else begin
			busy_len_q <= busy ? busy_len_q + 1 : 0;
		end
	end
	a_read_answer: assert property (rd_req |=> rd_valid)
		else $error("read not answered");
	a_capture_set: assert property (cap |=> capture_on == $past(cmd_data[`FPC_MISC_CAPTURE_BIT]))
		else $error("capture mode wrong");
	a_save_start: assert property (save && !output_enabled |=> busy)
		else $error("save not started");
	a_save_refused: assert property (save && output_enabled |-> ##2 !busy)
		else $error("save while enabled");
	a_busy_span: assert property ($fell(busy) |-> busy_len_q inside {1, 2, 33, SAVE_CYCLES})
		else $error("busy span wrong");
	a_fault_save: assert property (fault_event && fault_shutdown && !busy |-> ##[1:3] busy)
		else $error("no fault save");
	a_retry_quiet: assert property (fault_event && !fault_shutdown && !busy && !cmd_valid |=> ##1 !busy)
		else $error("retry fault saved");
	a_restore_cfg: assert property (go && cmd_code == `FPC_CMD_RESTORE_DEFAULT && !cmd_has_data
		|-> ##[1:3] config_out == default_config)
		else $error("default not applied");
endmodule : fpc_capture_chk

bind fpc_capture fpc_capture_chk #(
	.SAVE_CYCLES(SAVE_CYCLES)
) u_chk (
	.clk            (clk),
	.rst_n          (rst_n),
	.cmd_valid      (cmd_valid),
	.cmd_code       (cmd_code),
	.cmd_has_data   (cmd_has_data),
	.cmd_data       (cmd_data),
	.rd_req         (rd_req),
	.rd_valid       (rd_valid),
	.output_enabled (output_enabled),
	.fault_event    (fault_event),
	.fault_shutdown (fault_shutdown),
	.capture_on     (capture_on),
	.busy           (busy),
	.config_out     (config_out),
	.default_config (default_config)
);

// [fpc_host_model.sv]
`timescale 1ns/100ps
module fpc_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid,
	output logic            cmd_valid = 1'b0,
	output logic [7:0]      cmd_code = 8'h00,
	output logic            cmd_has_data = 1'b0,
	output logic [7:0]      cmd_data = 8'h00,
	output logic            rd_req = 1'b0,
	output logic [4:0]      rd_index = 5'h00
);
	// Capture mode is never written to a store; send-byte has no data
	task automatic send(input logic [7:0] code, input logic has, input logic [7:0] data);
		@(posedge clk);
		cmd_valid <= 1;
		cmd_code <= code;
		cmd_has_data <= has;
		cmd_data <= data;
		@(posedge clk);
		cmd_valid <= 0;
		cmd_data <= ~data;
	endtask : send
	task automatic read(input logic [4:0] idx, output logic [7:0] b);
		@(posedge clk);
		rd_req <= 1;
		rd_index <= idx;
		@(posedge clk);
		rd_req <= 0;
		rd_index <= ~idx;
		#1 b = rd_valid === 1'b1 ? rd_data : 8'hxx;
	endtask : read
endmodule : fpc_host_model

// [tb_top.sv]
`timescale 1ns/100ps
`include "fpc_regs.svh"
module tb_top;
	localparam int SAVE_CYC = 40;
	logic clk = 1'b0, rst_n = 1'b0, fw_tick = 1'b0;
	logic output_enabled = 1'b1, fault_event = 1'b0, fault_shutdown = 1'b0;
	logic [255:0] live_params = '0;
	logic [63:0] default_config = 64'h0123456789abcdef, config_out;
	logic cmd_valid, cmd_has_data, rd_valid, rd_req, capture_on, busy, config_valid;
	logic [7:0] cmd_code, cmd_data, rd_data, b;
	logic [4:0] rd_index;
	int err_total = 0, n_tests = 0;
	always #25 clk = ~clk;
	fpc_capture #(
		.SAVE_CYCLES(SAVE_CYC)
	) dut (
		.clk            (clk),
		.rst_n          (rst_n),
		.cmd_valid      (cmd_valid),
		.cmd_code       (cmd_code),
		.cmd_has_data   (cmd_has_data),
		.cmd_data       (cmd_data),
		.rd_req         (rd_req),
		.rd_index       (rd_index),
		.rd_data        (rd_data),
		.rd_valid       (rd_valid),
		.fw_tick        (fw_tick),
		.live_params    (live_params),
		.output_enabled (output_enabled),
		.fault_event    (fault_event),
		.fault_shutdown (fault_shutdown),
		.capture_on     (capture_on),
		.busy           (busy),
		.config_out     (config_out),
		.config_valid   (config_valid),
		.default_config (default_config)
	);
	fpc_host_model host (
		.clk          (clk),
		.rd_data      (rd_data),
		.rd_valid     (rd_valid),
		.cmd_valid    (cmd_valid),
		.cmd_code     (cmd_code),
		.cmd_has_data (cmd_has_data),
		.cmd_data     (cmd_data),
		.rd_req       (rd_req),
		.rd_index     (rd_index)
	);
	task automatic chk(input logic [63:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input logic [255:0] v);
		@(posedge clk) live_params <= v;
		fw_tick <= 1;
		@(posedge clk) fw_tick <= 0;
	endtask : tick
	task automatic idle;
		#1;
		for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk) #1;
		chk(busy, 1'b0);
	endtask : idle
	task automatic do_reset;
		@(posedge clk) rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(config_out, default_config);
		chk(config_valid, 1'b1);
		chk(capture_on, 1'b0);
	endtask : do_reset
	task automatic fault(input logic sh);
		@(posedge clk) fault_event <= 1'b1;
		fault_shutdown <= sh;
		@(posedge clk) fault_event <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(busy, sh);
		idle;
	endtask : fault
	task automatic t_capture;
		host.send(`FPC_CMD_MISC_CONFIG, 1'b1, 8'h02);
		#1 chk(capture_on, 1'b1);
		tick({8{32'ha5c30f1e}});
		host.read(5'h00, b);
		chk(b, 8'h1e);
		host.read(5'h1f, b);
		chk(b, 8'ha5);
		host.send(`FPC_CMD_MISC_CONFIG, 1'b1, 8'h00);
		#1 chk(capture_on, 1'b0);
		tick('1);
		host.read(5'h00, b);
		chk(b, 8'h1e);
		$display("capture test done");
	endtask : t_capture
	task automatic t_save;
		host.send(`FPC_CMD_STORE_CONTROL, 1'b1, `FPC_CTRL_SAVE);
		repeat (2) @(posedge clk);
		#1 chk(busy, 1'b0);
		@(posedge clk) output_enabled <= 1'b0;
		host.send(`FPC_CMD_STORE_CONTROL, 1'b1, `FPC_CTRL_SAVE);
		repeat (SAVE_CYC - 1) @(posedge clk);
		#1 chk(busy, 1'b1);
		@(posedge clk) #1 chk(busy, 1'b0);
		host.send(`FPC_CMD_MISC_CONFIG, 1'b1, 8'h02);
		tick('0);
		host.send(`FPC_CMD_MISC_CONFIG, 1'b1, 8'h00);
		do_reset;
		host.send(`FPC_CMD_STORE_CONTROL, 1'b1, `FPC_CTRL_RELOAD);
		idle;
		host.read(5'h00, b);
		chk(b, 8'h1e);
		host.read(5'h1f, b);
		chk(b, 8'ha5);
		$display("save test done");
	endtask : t_save
	task automatic t_fault_restore;
		fault(1'b0);
		fault(1'b1);
		@(posedge clk) default_config <= 64'hfedcba9876543210;
		host.send(`FPC_CMD_RESTORE_DEFAULT, 1'b0, 8'h00);
		idle;
		chk(config_out, 64'hfedcba9876543210);
		$display("fault and restore test done");
	endtask : t_fault_restore
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		do_reset;
		t_capture;
		t_save;
		t_fault_restore;
		complete_run;
	end
	initial begin
		#100000;
		err_total++;
		complete_run;
	end
endmodule : tb_top
